/* verilog/coef_cmd_unit.sv */
// Command interpreter for per-pixel coefficient write, save, load and reset
`timescale 1ns/100ps
module coef_cmd_unit
    import coef_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cmd_s cmd,
    output logic rsp_valid,
    output rsp_s rsp,
    output logic set_sel,
    output logic pix_wr,
    output logic [ADDR_W-1:0] pix_addr,
    output logic [7:0] pix_coef,
    output logic [8:0] pix_gain,
    output logic mv_valid,
    output move_e mv_kind,
    output logic [ADDR_W-1:0] mv_addr,
    input wire logic mv_ready
);
    typedef enum logic [1:0] {S_IDLE, S_SWEEP, S_REPLY} state_e;

    // Sequencer and selection state
    state_e state_r, state_nxt;
    logic set_r;
    move_e kind_r;

    // Answer path
    rsp_s rsp_r;
    rsp_s rsp_nxt;
    logic rsp_valid_r;

    // Single-pixel write path
    logic pix_wr_r;
    logic [ADDR_W-1:0] pix_addr_r;
    logic [7:0] pix_coef_r;
    logic [8:0] pix_gain_r;

    // Sweep engine hookup
    logic sweep_start;
    logic sweep_busy;
    logic sweep_done;
    logic [ADDR_W-1:0] sweep_addr;

    // One bit per operation code, decoded once for the checks and takes below
    logic [int'(OP_SELECT):0] op_hit_w;

    // Range check of a single-pixel write
    function automatic logic pixel_ok(input cmd_s c);
        pixel_ok = (c.col >= COL_MIN) && (c.col <= COL_MAX) && (c.row >= ROW_MIN)
            && (c.row <= ROW_MAX) && (c.value[8] == 1'b0);
    endfunction : pixel_ok

    // Pixel write, save and reset commands are locked out under the factory set; load is not
    function automatic logic needs_user(input op_e op);
        needs_user = (op == OP_PIXEL) || (op == OP_SAVE_GAIN) || (op == OP_SAVE_OFS)
            || (op == OP_RESET);
    endfunction : needs_user

    // Operation decode; the loop keeps the one-hot vector in step with the enum
    for (genvar g = 0; g <= int'(OP_SELECT); g++) begin : g_op_hit
        assign op_hit_w[g] = (cmd.op == op_e'(g));
    end

    // Accept, lock-out and argument checks of the offered command
    wire take_w = cmd_valid & cmd_ready;
    wire locked_w = needs_user(cmd.op) & (set_r == SET_FACTORY);
    wire pix_good_w = ~op_hit_w[OP_PIXEL] | pixel_ok(cmd);
    wire refuse_w = locked_w | ~pix_good_w;
    // Bulk operations walk addresses 0 to LAST_ADDR, so they go through the sweep engine
    wire bulk_w = op_hit_w[OP_SAVE_GAIN] | op_hit_w[OP_SAVE_OFS] | op_hit_w[OP_LOAD] | op_hit_w[OP_RESET];
    // Accepted good pixel write and accepted select, feeding the pixel strobe and word registers and the set register below
    wire pix_take_w = take_w & ~refuse_w & op_hit_w[OP_PIXEL];
    wire sel_take_w = take_w & op_hit_w[OP_SELECT];
    // Row-major pixel index, zero based; a product of 11 and 12 bits fits 21 bits for valid ranges
    wire [ADDR_W-1:0] row0_w = ADDR_W'(cmd.row - ROW_MIN);
    wire [ADDR_W-1:0] col0_w = ADDR_W'(cmd.col - COL_MIN);
    wire [ADDR_W-1:0] lin_w = ADDR_W'(row0_w * ADDR_W'(ROW_SIZE)) + col0_w;

    // Ready only while idle, so a busy unit holds the host off
    assign cmd_ready = (state_r == S_IDLE);
    assign sweep_start = take_w & ~refuse_w & bulk_w;

    // Registered results straight to the ports
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign set_sel = set_r;
    assign pix_wr = pix_wr_r;
    assign pix_addr = pix_addr_r;
    assign pix_coef = pix_coef_r;
    assign pix_gain = pix_gain_r;

    // Move bus: valid is the sweep's busy flag, address its counter
    assign mv_valid = sweep_busy;
    assign mv_kind = kind_r;
    assign mv_addr = sweep_addr;

    // Load follows the selection; reset wipes live and saved user words together
    function automatic move_e move_of(input op_e op, input logic sel);
        case (op)
            OP_SAVE_GAIN: move_of = MV_SAVE_GAIN;
            OP_SAVE_OFS: move_of = MV_SAVE_OFS;
            OP_LOAD: move_of = (sel == SET_USER) ? MV_LOAD_USER : MV_LOAD_FACTORY;
            OP_RESET: move_of = MV_CLEAR;
            default: move_of = MV_CLEAR;
        endcase
    endfunction : move_of

    // Answer chosen at command accept; bulk moves answer once the sweep ends
    always_comb begin
        rsp_nxt.kind = refuse_w ? RSP_ERROR : RSP_OK;
        rsp_nxt.set_num = set_r;
        if (!refuse_w && cmd.op == OP_GET_SET) begin
            rsp_nxt.kind = RSP_SET;
        end
        if (!refuse_w && cmd.op == OP_SELECT) begin
            rsp_nxt.set_num = cmd.set_sel;
        end
    end

    // Sequencer: idle, sweep over addresses 0 to LAST_ADDR, or hold a pending answer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (sweep_start) begin
                    state_nxt = S_SWEEP;
                end else if (take_w) begin
                    state_nxt = S_REPLY;
                end
            end
            S_SWEEP: begin
                if (sweep_done) begin
                    state_nxt = S_REPLY;
                end
            end
            S_REPLY: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Current coefficient set; only an accepted select moves it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            set_r <= SET_RESET;
        end else if (clk_en && sel_take_w) begin
            set_r <= cmd.set_sel;
        end
    end

    // Answer word stands from one accept to the next
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_r <= '{kind: RSP_OK, set_num: SET_RESET};
        end else if (clk_en && take_w) begin
            rsp_r <= rsp_nxt;
        end
    end

    // Answer strobe trails the reply state by one cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_r <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_r <= (state_r == S_REPLY);
        end
    end

    // Move kind is latched at accept so the store never sees it change mid-sweep
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            kind_r <= MV_CLEAR;
        end else if (clk_en && take_w) begin
            kind_r <= move_of(cmd.op, set_r);
        end
    end

    // Write strobe pulses once per accepted good pixel write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pix_wr_r <= 1'b0;
        end else if (clk_en) begin
            pix_wr_r <= pix_take_w;
        end
    end

    // Pixel word; gain is 1 + value/256 as a 1.8 fixed-point word
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pix_addr_r <= '0;
            pix_coef_r <= 8'h00;
            pix_gain_r <= 9'h100;
        end else if (clk_en && pix_take_w) begin
            pix_addr_r <= lin_w;
            pix_coef_r <= cmd.value[7:0];
            pix_gain_r <= {1'b1, cmd.value[7:0]};
        end
    end

    // Bulk moves stall on the store's ready, so a slow memory is never overrun
    coef_sweep u_sweep (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(sweep_start),
        .mem_ready(mv_ready),
        .busy(sweep_busy),
        .addr(sweep_addr),
        .step(),
        .done(sweep_done)
    );
endmodule : coef_cmd_unit

/* verilog/coef_cmd_pkg.sv */
// Package of constants and types for the pixel coefficient command unit
// Function
// - The unit accepts an 8-bit coefficient 0..255 and applies gain 1 + value/256 to that pixel.
// - A single-pixel write is refused under the factory set (0) and allowed under the user set (1).
// - A query of the coefficient-set selection answers with the current set number.
// - Save-gain copies all current gain coefficients to non-volatile storage; the sweep stops at LAST_ADDR, 33792 words short.
// - Save-gain is refused with an error while the factory set is active.
// - Save-offset copies all current offset coefficients to non-volatile storage; the sweep stops at LAST_ADDR, 33792 words short.
// - Save-offset runs only after the user set has been selected.
// - Load restores coefficients from storage, either the last saved user set or the factory set.
// - The set that load restores follows the current selection.
// - Reset clears every current user coefficient to zero; the sweep stops at LAST_ADDR, 33792 pixels short.
// - Reset also zeroes the saved user coefficients so that raw video results.
package coef_cmd_pkg;
    localparam int COL_W = 11;
    localparam int ROW_W = 11;
    localparam int ADDR_W = 21;
    localparam logic [COL_W-1:0] COL_MIN = 11'h001;
    localparam logic [COL_W-1:0] COL_MAX = 11'h578; // 1400
    localparam logic [ROW_W-1:0] ROW_MIN = 11'h001;
    localparam logic [ROW_W-1:0] ROW_MAX = 11'h400; // 1024
    localparam logic [ROW_W:0] ROW_SIZE = 12'h578; // Pixels per row
    localparam logic [ADDR_W-1:0] LAST_ADDR = 21'h155BFF; // 1399807, short of the last pixel index 1400*1024-1
    localparam logic SET_FACTORY = 1'b0;
    localparam logic SET_USER = 1'b1;
    localparam logic SET_RESET = SET_FACTORY;

    typedef enum logic [2:0] {
        OP_PIXEL, OP_SAVE_GAIN, OP_SAVE_OFS, OP_LOAD, OP_RESET, OP_GET_SET, OP_SELECT
    } op_e;

    typedef struct packed {
        op_e op;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        logic [8:0] value; // Nine bits so an over-range value can be seen
        logic set_sel;
    } cmd_s;

    typedef enum logic [1:0] {RSP_OK, RSP_ERROR, RSP_SET} rsp_kind_e;

    typedef struct packed {
        rsp_kind_e kind;
        logic set_num;
    } rsp_s;

    // Memory move request toward the coefficient store
    typedef enum logic [2:0] {
        MV_SAVE_GAIN, MV_SAVE_OFS, MV_LOAD_USER, MV_LOAD_FACTORY, MV_CLEAR
    } move_e;
endpackage : coef_cmd_pkg

/* verilog/coef_sweep.sv */
// Address sweep engine walking addresses 0 to LAST_ADDR once for bulk coefficient moves
`timescale 1ns/100ps
module coef_sweep
    import coef_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic mem_ready,
    output logic busy,
    output logic [ADDR_W-1:0] addr,
    output logic step,
    output logic done
);
    logic busy_r;
    logic [ADDR_W-1:0] addr_r;
    logic done_r;
    wire last_w = (addr_r == LAST_ADDR);

    assign step = busy_r & mem_ready;
    assign busy = busy_r;
    assign addr = addr_r;
    assign done = done_r;

    // Advance one pixel each time the store takes a word
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            addr_r <= '0;
            done_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= step & last_w;
            if (start & ~busy_r) begin
                busy_r <= 1'b1;
                addr_r <= '0;
            end else if (step) begin
                busy_r <= ~last_w;
                addr_r <= last_w ? '0 : addr_r + 21'h000001;
            end
        end
    end
endmodule : coef_sweep

/* tb/coef_cmd_unit_assertions.sv */
// Port checks for the coefficient command unit
`timescale 1ns/100ps
module coef_cmd_unit_assertions
    import coef_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire cmd_s cmd,
    input wire logic rsp_valid,
    input wire rsp_s rsp,
    input wire logic set_sel,
    input wire logic pix_wr,
    input wire logic [ADDR_W-1:0] pix_addr,
    input wire logic [7:0] pix_coef,
    input wire logic [8:0] pix_gain,
    input wire logic mv_valid,
    input wire move_e mv_kind,
    input wire logic [ADDR_W-1:0] mv_addr,
    input wire logic mv_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Command take and pixel argument window
    wire take = clk_en && cmd_valid && cmd_ready;
    wire in_rng = cmd.col >= COL_MIN && cmd.col <= COL_MAX && cmd.row >= ROW_MIN && cmd.row <= ROW_MAX && !cmd.value[8];
    wire bulk = cmd.op == OP_SAVE_GAIN || cmd.op == OP_SAVE_OFS || cmd.op == OP_RESET;
    pix_refuse_a: assert property (take && cmd.op == OP_PIXEL && !(set_sel && in_rng) |=>
        !pix_wr ##1 rsp_valid && rsp.kind == RSP_ERROR) else $error("bad pixel write not refused");
    pix_write_a: assert property (take && cmd.op == OP_PIXEL && set_sel && in_rng |=> pix_wr &&
        pix_coef == $past(cmd.value[7:0]) && pix_addr == ADDR_W'(($past(cmd.row) - 1) * 1400 + $past(cmd.col) - 1))
        else $error("pixel write data wrong");
    gain_form_a: assert property (pix_wr |-> pix_gain == {1'b1, pix_coef}) else $error("gain not one plus value");
    get_set_a: assert property (take && cmd.op == OP_GET_SET |-> ##2 rsp_valid && rsp.kind == RSP_SET &&
        rsp.set_num == set_sel) else $error("set query answer wrong");
    bulk_refuse_a: assert property (take && bulk && !set_sel |=> !mv_valid ##1 rsp_valid &&
        rsp.kind == RSP_ERROR) else $error("factory set did not refuse");
    bulk_kind_a: assert property (take && bulk && set_sel |=> mv_valid && mv_addr == 0 &&
        mv_kind == ($past(cmd.op) == OP_SAVE_GAIN ? MV_SAVE_GAIN : $past(cmd.op) == OP_SAVE_OFS ? MV_SAVE_OFS : MV_CLEAR))
        else $error("bulk move kind wrong");
    load_kind_a: assert property (take && cmd.op == OP_LOAD |=> mv_valid && mv_addr == 0 &&
        mv_kind == ($past(set_sel) ? MV_LOAD_USER : MV_LOAD_FACTORY)) else $error("load source wrong");
    sweep_step_a: assert property (mv_valid && mv_ready && clk_en && mv_addr != LAST_ADDR |=> mv_valid &&
        mv_addr == $past(mv_addr) + 1'b1) else $error("sweep did not advance");
    sweep_hold_a: assert property (mv_valid && !mv_ready |=> mv_valid && $stable(mv_addr))
        else $error("sweep lost a stalled word");
endmodule : coef_cmd_unit_assertions

/* tb/coef_store_model.sv */
// Coefficient store model taking sweep words with random stalls
`timescale 1ns/100ps
module coef_store_model (
    input wire logic ref_clk,
    input wire logic mv_valid,
    output logic mv_ready
);
    // Stalls about a third of the time so the sweep must hold its word
    initial mv_ready = 1'b0;
    always @(posedge ref_clk) begin
        mv_ready <= mv_valid && ($urandom % 3) != 0;
    end
endmodule : coef_store_model

/* tb/pixel_coefficient_command_unit_test.sv */
// Self-checking bench for the coefficient command unit
`timescale 1ns/100ps
module pixel_coefficient_command_unit_test
    import coef_cmd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_s cmd = '0;
    logic cmd_ready, rsp_valid, set_sel, pix_wr, mv_valid, mv_ready;
    rsp_s rsp;
    logic [ADDR_W-1:0] pix_addr, mv_addr;
    logic [7:0] pix_coef;
    logic [8:0] pix_gain;
    move_e mv_kind;
    int num_errors = 0;
    int checked = 0;
    int model_set = 0;
    int bc[7] = '{1, 1400, 0, 1401, 1, 1, 1};
    int br[7] = '{1, 1024, 1, 1, 0, 1025, 1};
    int bv[7] = '{0, 255, 5, 5, 5, 5, 256};
    always #25 ref_clk = ~ref_clk;
    coef_cmd_unit u_dut (.ref_clk, .sys_rst, .clk_en, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .set_sel,
        .pix_wr, .pix_addr, .pix_coef, .pix_gain, .mv_valid, .mv_kind, .mv_addr, .mv_ready);
    coef_store_model u_store (.ref_clk, .mv_valid, .mv_ready);
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic do_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        clk_en <= 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        model_set = 0;
    endtask : do_reset
    // One command: model the answer, offer it, then check each stage
    task automatic do_cmd(input op_e op, input int col, input int row, input int val, input int sel);
        int n;
        int good;
        int exp_kind;
        n = 0;
        good = op == OP_PIXEL && model_set && col >= 1 && col <= 1400 && row >= 1 && row <= 1024 && val < 256;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, col[10:0], row[10:0], val[8:0], sel[0]};
        do begin
            @(negedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
        if (op == OP_PIXEL) begin
            chk("pix_wr", pix_wr, good);
            if (good) begin
                chk("pix_addr", pix_addr, (row - 1) * 1400 + col - 1);
                chk("pix_coef", pix_coef, val);
                chk("pix_gain", pix_gain, 256 + val);
            end
        end
        if (op != OP_PIXEL && op < OP_GET_SET && (op == OP_LOAD || model_set)) begin
            chk("mv_valid", mv_valid, 1);
            exp_kind = op == OP_LOAD ? (model_set ? MV_LOAD_USER : MV_LOAD_FACTORY) :
                op == OP_SAVE_GAIN ? MV_SAVE_GAIN : op == OP_SAVE_OFS ? MV_SAVE_OFS : MV_CLEAR;
            chk("mv_kind", mv_kind, exp_kind);
            n = 0;
            // Full sweep is far too long: count words taken under random freezes, then abort by reset
            repeat (120) begin
                n += mv_valid && mv_ready && clk_en;
                @(posedge ref_clk);
                clk_en <= ($urandom % 4) != 0;
                @(negedge ref_clk);
            end
            chk("mv_addr", mv_addr, n);
            do_reset();
        end else begin
            chk("mv_valid", mv_valid, 0);
            @(negedge ref_clk);
            chk("rsp_valid", rsp_valid, 1);
            chk("rsp_kind", rsp.kind, op == OP_GET_SET ? RSP_SET : (op == OP_SELECT || good) ? RSP_OK : RSP_ERROR);
            if (op == OP_GET_SET) begin
                chk("set_num", rsp.set_num, model_set);
            end
            if (op == OP_SELECT) begin
                model_set = sel;
            end
            chk("set_sel", set_sel, model_set);
        end
    endtask : do_cmd
    initial begin
        void'($urandom(29920));
        do_reset();
        do_cmd(OP_GET_SET, 1, 1, 0, 0);
        for (int op = 0; op < 5; op++) begin
            do_cmd(op_e'(op), 5, 5, 9, 0);
        end
        do_cmd(OP_SELECT, 1, 1, 0, 1);
        do_cmd(OP_GET_SET, 1, 1, 0, 0);
        for (int i = 0; i < 7; i++) begin
            do_cmd(OP_PIXEL, bc[i], br[i], bv[i], 0);
        end
        repeat (20) begin
            do_cmd(OP_PIXEL, $urandom % 1402, $urandom % 1026, $urandom % 300, 0);
        end
        for (int op = 1; op < 5; op++) begin
            do_cmd(OP_SELECT, 1, 1, 0, 1);
            do_cmd(op_e'(op), 1, 1, 0, 0);
        end
        final_report();
    end
endmodule : pixel_coefficient_command_unit_test
bind coef_cmd_unit coef_cmd_unit_assertions u_chk (.ref_clk, .sys_rst, .clk_en, .cmd_valid, .cmd_ready, .cmd,
    .rsp_valid, .rsp, .set_sel, .pix_wr, .pix_addr, .pix_coef, .pix_gain, .mv_valid, .mv_kind, .mv_addr, .mv_ready);
